// ==== logic/rpat_pkg.sv ====
// Package for the radio packet auxiliary timing and direction-finding block
package rpat_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_IFSGAP   = 8'h04;
  localparam logic [7:0] OFS_MATCHCFG = 8'h08;
  localparam logic [7:0] OFS_BCCMP    = 8'h0C;
  localparam logic [7:0] OFS_DFCFG    = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_BCCOUNT  = 8'h18;
  localparam logic [7:0] OFS_CTESTAT  = 8'h1C;
  localparam logic [7:0] OFS_ADDRLO0  = 8'h40;
  localparam logic [7:0] OFS_ADDRHI0  = 8'h60;

  // Control register fields
  localparam int CTRL_SC_END_DIS = 0;
  localparam int CTRL_SC_DIS_TX  = 1;
  localparam int CTRL_SC_DIS_RX  = 2;
  localparam int CTRL_BITORDER   = 3;
  localparam int CTRL_MODE_LSB   = 4;
  localparam int CTRL_MODE_W     = 2;

  // Direction-finding config fields
  localparam int DF_MODE_LSB   = 0;
  localparam int DF_INLINE     = 2;
  localparam int DF_INS1       = 3;
  localparam int DF_SP1_LSB    = 4;
  localparam int DF_SP2_LSB    = 7;
  localparam int DF_SP_W       = 3;
  localparam int DF_RANGE_LSB  = 10;
  localparam int DF_MASK_LSB   = 16;
  localparam int DF_CMP_LSB    = 24;

  // Reset values
  localparam logic [31:0] CTRL_RST    = 32'h0000_0008;
  localparam logic [31:0] IFS_RST     = 32'h0000_0096;
  localparam logic [31:0] DFCFG_RST   = 32'h0000_7C00;

  // Radio modes, direction modes
  localparam logic [1:0] MODE_LE1M = 2'h0;
  localparam logic [1:0] MODE_LE2M = 2'h1;
  localparam logic [1:0] DFM_OFF   = 2'h0;
  localparam logic [1:0] DFM_AOD   = 2'h1;
  localparam logic [1:0] DFM_AOA   = 2'h2;

  // Packet layout
  localparam int ADDR_BITS     = 48;
  localparam int TXADD_BIT     = 6;
  localparam int EXT_SKIP_OCT  = 6;
  localparam int NUM_ADDR      = 8;

  // Timing
  localparam int CLK_MHZ        = 10;
  localparam int US_CYCLES      = CLK_MHZ;
  localparam int CTE_UNIT_US    = 8;
  localparam int CTE_MIN_US     = 16;
  localparam int CTE_MAX_US     = 160;
  localparam int TURNAROUND_US  = 40;
  localparam int TURNAROUND_CYC = TURNAROUND_US * CLK_MHZ;

  typedef enum logic [1:0] {
    RPAT_IDLE = 2'b00,
    RPAT_GAP  = 2'b01,
    RPAT_TX   = 2'b11,
    RPAT_CTE  = 2'b10
  } rpat_state_e;

  // Events, tasks and receive-side data from the radio core
  typedef struct packed {
    logic       rxBit;
    logic [7:0] rxByte;
    logic       rxByteValid;
    logic       addressEvt;
    logic       endEvt;
    logic       disabledEvt;
    logic       stopTask;
    logic       disableTask;
    logic       txEnTask;
    logic       rxEnTask;
    logic       bitTick;
    logic       receiving;
  } rpat_radio_s;

  // Decoded tone-extension setup
  typedef struct packed {
    logic       present;
    logic [7:0] lenUs;
    logic [1:0] cteType;
    logic [2:0] spacing;
    logic       switching;
    logic       toneGen;
  } rpat_cte_s;

endpackage : rpat_pkg

// ==== logic/rpat_aux_timing.sv ====
// Radio packet auxiliary logic: interframe gap, address match, bit counter, direction finding
`timescale 1ns/100ps

module rpat_aux_timing
  import rpat_pkg::*;
#(
  parameter int TURN_CYC = TURNAROUND_CYC
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Radio core events
  input  wire rpat_pkg::rpat_radio_s radioIn,
  input  wire logic                bitCounterStartTask,
  input  wire logic                crcDone,
  // Event outputs
  output logic                     bitCounterMatchEvent,
  output logic                     txFirstBit,
  output logic [NUM_ADDR-1:0]      addrMatch,
  output logic                     cteActive,
  output logic                     cteToneOne,
  output logic                     antennaSwitch,
  output logic                     iqSample
);
  import rpat_pkg::*;

  logic [31:0] ctrl_reg, ifs_reg, matchCfg_reg, bcCmp_reg, dfCfg_reg;
  logic [31:0] addrLo_reg [NUM_ADDR];
  logic [15:0] addrHi_reg [NUM_ADDR];
  logic        wrPend_reg;
  logic [7:0]  wrAddr_reg;
  logic [1:0]  modeLatched_reg;

  // AHB-Lite: zero wait states, always OKAY
  // Write data follows its address by one cycle, so the offset is held until then
  wire logic addrPhase = hsel && hready && htrans[1];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
    end else begin
      wrPend_reg <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_reg <= haddr[7:0];
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Shortcuts and gap written directly, take effect immediately
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg     <= CTRL_RST;
      ifs_reg      <= IFS_RST;
      matchCfg_reg <= 32'h0000_0000;
      bcCmp_reg    <= 32'h0000_0000;
      dfCfg_reg    <= DFCFG_RST;
      for (int i = 0; i < NUM_ADDR; i++) begin
        addrLo_reg[i] <= 32'h0000_0000;
        addrHi_reg[i] <= 16'h0000;
      end
    end else if (wrPend_reg) begin
      case (wrAddr_reg)
        OFS_CTRL:     ctrl_reg     <= hwdata;
        OFS_IFSGAP:   ifs_reg      <= {22'h000000, hwdata[9:0]};
        OFS_MATCHCFG: matchCfg_reg <= {16'h0000, hwdata[15:0]};
        OFS_BCCMP:    bcCmp_reg    <= {16'h0000, hwdata[15:0]};
        OFS_DFCFG:    dfCfg_reg    <= hwdata;
        default: begin
          for (int i = 0; i < NUM_ADDR; i++) begin
            if (wrAddr_reg == OFS_ADDRLO0 + 8'(4 * i)) addrLo_reg[i] <= hwdata;
            if (wrAddr_reg == OFS_ADDRHI0 + 8'(4 * i)) addrHi_reg[i] <= hwdata[15:0];
          end
        end
      endcase
    end
  end

  // Mode buffered at enable tasks
  // Mode changes mid-packet are ignored until the next enable task
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      modeLatched_reg <= MODE_LE1M;
    end else if (radioIn.txEnTask || radioIn.rxEnTask) begin
      modeLatched_reg <= ctrl_reg[CTRL_MODE_LSB +: CTRL_MODE_W];
    end
  end

  // Interframe gap
  // Counter starts at one on the end event so the pulse lands exactly on the gap
  rpat_state_e gapState_reg;
  logic [15:0] gapCnt_reg;
  wire logic   gapArmed = ctrl_reg[CTRL_SC_END_DIS] &&
                          (ctrl_reg[CTRL_SC_DIS_TX] || ctrl_reg[CTRL_SC_DIS_RX]);
  wire logic [15:0] gapTarget = 16'(ifs_reg[9:0] * US_CYCLES);
  wire logic [15:0] gapLimit  = (gapTarget > 16'(TURN_CYC)) ? gapTarget : 16'(TURN_CYC);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gapState_reg <= RPAT_IDLE;
      gapCnt_reg   <= 16'h0000;
      txFirstBit   <= 1'b0;
    end else begin
      txFirstBit <= 1'b0;
      case (gapState_reg)
        RPAT_IDLE: if (radioIn.endEvt && gapArmed) begin
          gapState_reg <= RPAT_GAP;
          gapCnt_reg   <= 16'h0001;
        end
        RPAT_GAP: begin
          if (gapCnt_reg >= gapLimit - 16'h0001) begin
            txFirstBit   <= 1'b1;
            gapState_reg <= RPAT_IDLE;
          end else begin
            gapCnt_reg <= gapCnt_reg + 16'h0001;
          end
        end
        default: gapState_reg <= RPAT_IDLE;
      endcase
    end
  end

  // Device address match
  logic [47:0] shAddr_reg;
  logic [5:0]  addrBits_reg;
  logic        txAdd_reg, hdrSeen_reg;
  wire logic   matchOn = radioIn.receiving && ctrl_reg[CTRL_BITORDER];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shAddr_reg   <= 48'h0000_0000_0000;
      addrBits_reg <= 6'h00;
      txAdd_reg    <= 1'b0;
      hdrSeen_reg  <= 1'b0;
      addrMatch    <= '0;
    end else if (radioIn.addressEvt || !matchOn) begin
      addrBits_reg <= 6'h00;
      hdrSeen_reg  <= 1'b0;
      if (!matchOn) addrMatch <= '0;
    end else begin
      if (radioIn.rxByteValid && !hdrSeen_reg) begin
        txAdd_reg   <= radioIn.rxByte[TXADD_BIT];
        hdrSeen_reg <= 1'b1;
      end
      if (radioIn.bitTick && hdrSeen_reg && addrBits_reg < 6'(ADDR_BITS)) begin
        shAddr_reg   <= {radioIn.rxBit, shAddr_reg[47:1]};
        addrBits_reg <= addrBits_reg + 6'h01;
        if (addrBits_reg == 6'(ADDR_BITS - 1)) begin
          for (int i = 0; i < NUM_ADDR; i++) begin
            addrMatch[i] <= matchCfg_reg[i] &&
                            ({radioIn.rxBit, shAddr_reg[47:1]} == {addrHi_reg[i], addrLo_reg[i]}) &&
                            (txAdd_reg == matchCfg_reg[NUM_ADDR + i]);
          end
        end
      end
    end
  end

  // Bit counter
  // A clear in the same cycle as a start wins, so no count survives the packet end
  logic        bcRun_reg;
  logic [15:0] bcCnt_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bcRun_reg            <= 1'b0;
      bcCnt_reg            <= 16'h0000;
      bitCounterMatchEvent <= 1'b0;
    end else begin
      bitCounterMatchEvent <= 1'b0;
      if (radioIn.stopTask || radioIn.disableTask || radioIn.endEvt || radioIn.disabledEvt) begin
        bcRun_reg <= 1'b0;
        bcCnt_reg <= 16'h0000;
      end else if (bitCounterStartTask) begin
        bcRun_reg <= 1'b1;
        bcCnt_reg <= 16'h0000;
      end else if (bcRun_reg && radioIn.bitTick) begin
        bcCnt_reg <= bcCnt_reg + 16'h0001;
        if (bcCnt_reg + 16'h0001 == bcCmp_reg[15:0]) bitCounterMatchEvent <= 1'b1;
      end
    end
  end

  // Inline CTE parsing
  logic [3:0]  byteIdx_reg;
  logic [7:0]  hdr0_reg;
  logic        cp_reg, s1Present_reg;
  logic [3:0]  infoIdx_reg;
  rpat_cte_s   cte_reg;
  wire logic   inlineOn = dfCfg_reg[DF_INLINE] && radioIn.receiving;
  wire logic   dataPdu  = dfCfg_reg[DF_INS1];
  wire logic [4:0] timeBound = dfCfg_reg[DF_RANGE_LSB +: 5];

  function automatic logic [7:0] cte_len_us(input logic [5:0] t, input logic [4:0] bound);
    logic [5:0] v;
    v = t;
    if (v < 6'h02) v = 6'h02;
    if (v > {1'b0, bound}) v = {1'b0, bound};
    cte_len_us = 8'(v * CTE_UNIT_US);
  endfunction

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      byteIdx_reg   <= 4'h0;
      hdr0_reg      <= 8'h00;
      cp_reg        <= 1'b0;
      s1Present_reg <= 1'b0;
      infoIdx_reg   <= 4'hF;
      cte_reg       <= '0;
    end else if (radioIn.addressEvt) begin
      byteIdx_reg <= 4'h0;
      infoIdx_reg <= 4'hF;
      cte_reg     <= '0;
    end else if (inlineOn && radioIn.rxByteValid && byteIdx_reg != 4'hF) begin
      byteIdx_reg <= byteIdx_reg + 4'h1;
      if (byteIdx_reg == 4'h0) begin
        hdr0_reg      <= radioIn.rxByte;
        s1Present_reg <= (radioIn.rxByte & dfCfg_reg[DF_MASK_LSB +: 8]) == dfCfg_reg[DF_CMP_LSB +: 8];
      end
      if (byteIdx_reg == 4'h1 && dataPdu) begin
        cp_reg <= radioIn.rxByte[5];
        if (s1Present_reg && radioIn.rxByte[5]) infoIdx_reg <= 4'h2;
      end
      if (byteIdx_reg == 4'h2 && !dataPdu && s1Present_reg && radioIn.rxByte[5:0] != 6'h00) begin
        infoIdx_reg <= 4'h3; // Flags octet follows ext header length
      end
      if (byteIdx_reg == 4'h3 && !dataPdu && infoIdx_reg == 4'h3) begin
        cp_reg      <= radioIn.rxByte[2];
        infoIdx_reg <= !radioIn.rxByte[2] ? 4'hF :
                       (|radioIn.rxByte[1:0]) ? 4'(4 + EXT_SKIP_OCT) : 4'h4;
      end
      if (byteIdx_reg == infoIdx_reg && byteIdx_reg != 4'h3) begin
        cte_reg.present   <= 1'b1;
        cte_reg.lenUs     <= cte_len_us(radioIn.rxByte[5:0], timeBound);
        cte_reg.cteType   <= radioIn.rxByte[7:6];
        cte_reg.switching <= radioIn.rxByte[7:6] == 2'h0; // AoA receive switches
        cte_reg.toneGen   <= 1'b0;
        case (radioIn.rxByte[7:6])
          2'h1:    cte_reg.spacing <= dfCfg_reg[DF_SP1_LSB +: DF_SP_W];
          2'h2:    cte_reg.spacing <= dfCfg_reg[DF_SP2_LSB +: DF_SP_W];
          default: cte_reg.spacing <= 3'h0;
        endcase
      end
    end
  end

  // Extension sequencer: guard 4 us, reference 8 us, then slots
  localparam logic [7:0] GUARD_END = 8'h04;
  localparam logic [7:0] REF_END   = 8'h0C;
  logic [7:0] cteUs_reg;
  logic [3:0] usDiv_reg;
  logic [7:0] cteLen_reg;
  logic       slotTwo_reg;
  wire logic [1:0] dfMode = dfCfg_reg[DF_MODE_LSB +: 2];
  wire logic  dfAllowed = modeLatched_reg == MODE_LE1M || modeLatched_reg == MODE_LE2M;
  wire logic  isTx = !radioIn.receiving;
  wire logic  doSwitch = (dfMode == DFM_AOA && !isTx) || (dfMode == DFM_AOD && isTx);
  wire logic  txStart = crcDone && isTx && dfMode != DFM_OFF && dfAllowed;
  wire logic  rxStart = crcDone && !isTx && dfMode != DFM_OFF && dfAllowed && (!inlineOn || cte_reg.present);
  wire logic [7:0] txLen = (cte_reg.lenUs < 8'(CTE_MIN_US)) ? 8'(CTE_MIN_US) :
                           (cte_reg.lenUs > 8'(CTE_MAX_US)) ? 8'(CTE_MAX_US) : cte_reg.lenUs;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cteActive     <= 1'b0;
      cteToneOne    <= 1'b0;
      antennaSwitch <= 1'b0;
      iqSample      <= 1'b0;
      cteUs_reg     <= 8'h00;
      usDiv_reg     <= 4'h0;
      cteLen_reg    <= 8'h00;
      slotTwo_reg   <= 1'b0;
    end else begin
      antennaSwitch <= 1'b0;
      iqSample      <= 1'b0;
      if (!cteActive) begin
        if (txStart || rxStart) begin
          cteActive   <= 1'b1;
          cteToneOne  <= isTx; // Ones, whitening bypassed
          cteLen_reg  <= isTx ? txLen : (inlineOn ? cte_reg.lenUs : 8'(CTE_MIN_US));
          slotTwo_reg <= cte_reg.cteType == 2'h2;
          cteUs_reg   <= 8'h00;
          usDiv_reg   <= 4'h0;
        end
      end else if (usDiv_reg == 4'(US_CYCLES - 1)) begin
        usDiv_reg <= 4'h0;
        cteUs_reg <= cteUs_reg + 8'h01;
        if (cteUs_reg + 8'h01 >= cteLen_reg) begin
          cteActive  <= 1'b0;
          cteToneOne <= 1'b0;
        end
        if (cteUs_reg < GUARD_END) begin
          antennaSwitch <= doSwitch && cteUs_reg == 8'h00;
        end else if (cteUs_reg < REF_END) begin
          iqSample <= !isTx;
        end else begin
          // Equal switch and sample slots of 1 or 2 us
          if (slotTwo_reg ? (cteUs_reg[1:0] == 2'h0) : !cteUs_reg[0]) antennaSwitch <= doSwitch;
          if (slotTwo_reg ? (cteUs_reg[1:0] == 2'h2) : cteUs_reg[0]) iqSample <= !isTx;
        end
      end else begin
        usDiv_reg <= usDiv_reg + 4'h1;
      end
    end
  end

  // Read mux: registered, so data stands in the data phase with no wait state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      case (haddr[7:0])
        OFS_CTRL:     hrdata <= ctrl_reg;
        OFS_IFSGAP:   hrdata <= ifs_reg;
        OFS_MATCHCFG: hrdata <= matchCfg_reg;
        OFS_BCCMP:    hrdata <= bcCmp_reg;
        OFS_DFCFG:    hrdata <= dfCfg_reg;
        // Status packs mode, gap state, counter run, extension and match bits
        OFS_STATUS:   hrdata <= {18'h00000, modeLatched_reg, gapState_reg, bcRun_reg, cteActive, addrMatch};
        OFS_BCCOUNT:  hrdata <= {16'h0000, bcCnt_reg};
        OFS_CTESTAT:  hrdata <= {16'h0000, cte_reg.present, cp_reg, cte_reg.cteType, 4'h0, cte_reg.lenUs};
        default: begin
          hrdata <= 32'h0000_0000;
          for (int i = 0; i < NUM_ADDR; i++) begin
            if (haddr[7:0] == OFS_ADDRLO0 + 8'(4 * i)) hrdata <= addrLo_reg[i];
            if (haddr[7:0] == OFS_ADDRHI0 + 8'(4 * i)) hrdata <= {16'h0000, addrHi_reg[i]};
          end
        end
      endcase
    end
  end

  wire logic unusedHdr = ^{hsize, hdr0_reg};

endmodule // rpat_aux_timing

// ==== test/rpat_aux_timing_assertions.sv ====
// Concurrent checks on the auxiliary timing block ports
`timescale 1ns/100ps
module rpat_aux_timing_assertions
  import rpat_pkg::*;
#(
  parameter int TURN_CYC = TURNAROUND_CYC
) (
  // Clock and reset
  input wire logic                          clock,
  input wire logic                          rst_n,
  // Watched ports
  input wire rpat_pkg::rpat_radio_s         radioIn,
  input wire logic                          bitCounterMatchEvent,
  input wire logic                          txFirstBit,
  input wire logic [rpat_pkg::NUM_ADDR-1:0] addrMatch,
  input wire logic                          cteActive,
  input wire logic                          cteToneOne
);
  logic [15:0] sinceEnd_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Saturates so a gap pulse long after the last packet end is still judged
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sinceEnd_reg <= 16'hFFFF;
    end else if (radioIn.endEvt) begin
      sinceEnd_reg <= 16'h0000;
    end else if (sinceEnd_reg != 16'hFFFF) begin
      sinceEnd_reg <= sinceEnd_reg + 16'h0001;
    end
  end

  a_match_one_pulse: assert property (bitCounterMatchEvent |=> !bitCounterMatchEvent)
    else $error("bit counter match longer than one cycle");
  a_match_after_tick: assert property (bitCounterMatchEvent |-> $past(radioIn.bitTick))
    else $error("bit counter match without a counted bit");
  a_clear_stops_match: assert property ((radioIn.stopTask || radioIn.disableTask || radioIn.endEvt) |=> !bitCounterMatchEvent)
    else $error("bit counter match right after a clear");
  a_gap_one_pulse: assert property (txFirstBit |=> !txFirstBit)
    else $error("first transmit bit pulse too long");
  a_gap_not_short: assert property (txFirstBit |-> sinceEnd_reg >= 16'(TURN_CYC - 1))
    else $error("transmit started inside the turnaround time");
  a_gap_quiet_start: assert property (radioIn.endEvt |=> (!txFirstBit) [*8])
    else $error("transmit started right after packet end");
  a_addr_idle_clear: assert property ((!radioIn.receiving) [*2] |-> (addrMatch == '0))
    else $error("address match shown while not receiving");
  a_tone_in_cte: assert property (cteToneOne |-> cteActive)
    else $error("tone of ones outside the tone extension");

  c_bit_match: cover property (bitCounterMatchEvent);
  c_gap_done: cover property (txFirstBit);
  c_addr_hit: cover property (addrMatch != '0);
  c_cte_tone: cover property (cteActive && cteToneOne);
endmodule // rpat_aux_timing_assertions

bind rpat_aux_timing rpat_aux_timing_assertions #(.TURN_CYC(TURN_CYC)) u_chk (
  .clock(clock), .rst_n(rst_n), .radioIn(radioIn), .bitCounterMatchEvent(bitCounterMatchEvent),
  .txFirstBit(txFirstBit), .addrMatch(addrMatch), .cteActive(cteActive), .cteToneOne(cteToneOne));

// ==== test/rpat_peer_radio.sv ====
// Peer radio model sending a header byte and a device address over the air
`timescale 1ns/100ps
module rpat_peer_radio
  import rpat_pkg::*;
(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst_n,
  // Frame request
  input  wire logic          sendReq,
  input  wire logic [55:0]   frame,
  input  wire logic [3:0]    bitGap,
  // Air side
  output rpat_pkg::rpat_radio_s radioOut,
  output logic               busy
);
  logic [5:0]  bitIdx_reg;
  logic [3:0]  gapCnt_reg;
  logic [55:0] frame_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      radioOut   <= '0;
      busy       <= 1'b0;
      bitIdx_reg <= 6'h00;
      gapCnt_reg <= 4'h0;
      frame_reg  <= '0;
    end else begin
      radioOut.addressEvt  <= sendReq && !busy;
      radioOut.bitTick     <= 1'b0;
      radioOut.rxByteValid <= 1'b0;
      // Lines between bits toggle so stale data is never read as valid
      radioOut.rxBit  <= ~radioOut.rxBit;
      radioOut.rxByte <= ~radioOut.rxByte;
      if (sendReq && !busy) begin
        busy       <= 1'b1;
        frame_reg  <= frame;
        bitIdx_reg <= 6'h00;
        gapCnt_reg <= bitGap;
      end else if (busy && gapCnt_reg != 4'h0) begin
        gapCnt_reg <= gapCnt_reg - 4'h1;
      end else if (busy) begin
        radioOut.bitTick <= 1'b1;
        radioOut.rxBit   <= frame_reg[bitIdx_reg];
        gapCnt_reg       <= bitGap;
        bitIdx_reg       <= bitIdx_reg + 6'h01;
        if (bitIdx_reg[2:0] == 3'h7) begin
          radioOut.rxByteValid <= 1'b1;
          radioOut.rxByte      <= frame_reg[{bitIdx_reg[5:3], 3'h0} +: 8];
        end
        busy <= (bitIdx_reg != 6'h37);
      end
    end
  end
endmodule // rpat_peer_radio

// ==== test/tb.sv ====
// Self-checking bench for the radio packet auxiliary block
`timescale 1ns/100ps
module tb;
  import rpat_pkg::*;
  localparam int TURN = 20;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire logic   hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        bit_counter_start_task = 1'b0;
  logic        bit_counter_match_event;
  logic        txFirstBit;
  logic [7:0]  addrMatch;
  logic        crcDone = 1'b0;
  logic        cteActive;
  logic        cteToneOne;
  logic        antSw;
  logic        iqSample;
  logic        sendReq = 1'b0;
  logic [55:0] frame = '0;
  logic        busy;
  rpat_radio_s benchEvt = '0;
  rpat_radio_s peerOut;
  rpat_radio_s radioIn;
  logic [15:0] lfsr = 16'h34A9;
  logic [47:0] tab [8];
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;
  int          matchCnt = 0;

  assign hready = hreadyout;
  assign radioIn = peerOut | benchEvt;
  always #50 clock = ~clock;

  rpat_aux_timing #(.TURN_CYC(TURN)) dut (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .radioIn(radioIn), .bitCounterStartTask(bit_counter_start_task), .crcDone(crcDone), .bitCounterMatchEvent(bit_counter_match_event),
    .txFirstBit(txFirstBit), .addrMatch(addrMatch), .cteActive(cteActive), .cteToneOne(cteToneOne),
    .antennaSwitch(antSw), .iqSample(iqSample));

  rpat_peer_radio peer (
    .clock(clock), .rst_n(rst_n), .sendReq(sendReq), .frame(frame), .bitGap(4'h9),
    .radioOut(peerOut), .busy(busy));

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic void draw(output logic [31:0] v);
    for (int i = 0; i < 2; i++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      v = {v[15:0], lfsr};
    end
  endfunction

  // Entered right after a rising edge; one whole-word single transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  function automatic int gapCycles(input int ifs);
    return (ifs * US_CYCLES > TURN) ? ifs * US_CYCLES : TURN;
  endfunction

  function automatic logic [7:0] expMatch(input logic [47:0] a, input logic [7:0] hdr, input logic [15:0] cfg);
    expMatch = 8'h00;
    for (int i = 0; i < NUM_ADDR; i++) begin
      expMatch[i] = cfg[i] && tab[i] == a && cfg[8 + i] == hdr[TXADD_BIT];
    end
  endfunction

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (bit_counter_match_event === 1'b1) matchCnt <= matchCnt + 1;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    logic [31:0] w;
    logic [31:0] rd;
    logic [47:0] a;
    int n;
    int nSw;
    int nIq;
    logic [7:0] ctl [4] = '{8'h0B, 8'h0D, 8'h09, 8'h0A};
    int ifs [4] = '{5, 1, 5, 5};
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, OFS_CTRL, 32'h0, rd);
    check(rd, CTRL_RST);
    bus(1'b0, OFS_IFSGAP, 32'h0, rd);
    check(rd, IFS_RST);
    bus(1'b0, OFS_DFCFG, 32'h0, rd);
    check(rd, DFCFG_RST);
    draw(w);
    bus(1'b1, 8'h3C, w, rd);
    bus(1'b0, 8'h3C, 32'h0, rd);
    check(rd, 32'h0);
    draw(w);
    a[31:0] = w;
    draw(w);
    a[47:32] = w[15:0];
    // Entries 0 to 2 hold the same address but differ in TxAdd or enable
    for (int i = 0; i < NUM_ADDR; i++) begin
      draw(w);
      tab[i] = (i < 3) ? a : (i == 3) ? a ^ 48'h1 : {16'h0, w};
      bus(1'b1, OFS_ADDRLO0 + 8'(4 * i), tab[i][31:0], rd);
      bus(1'b1, OFS_ADDRHI0 + 8'(4 * i), {16'h0, tab[i][47:32]}, rd);
      bus(1'b0, OFS_ADDRLO0 + 8'(4 * i), 32'h0, rd);
      check(rd, tab[i][31:0]);
    end
    bus(1'b1, OFS_MATCHCFG, 32'h0000_090B, rd);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, OFS_CTRL, k ? 32'h8 : 32'h0, rd);
      bus(1'b1, OFS_BCCMP, 32'h3, rd);
      matchCnt = 0;
      benchEvt.receiving <= 1'b1;
      frame <= {a, 8'h40};
      sendReq <= 1'b1;
      @(posedge clock);
      sendReq <= 1'b0;
      do @(posedge clock); while (radioIn.addressEvt !== 1'b1);
      bit_counter_start_task <= 1'b1;
      @(posedge clock);
      bit_counter_start_task <= 1'b0;
      do @(posedge clock); while (bit_counter_match_event !== 1'b1);
      bus(1'b1, OFS_BCCMP, 32'hA, rd);
      do @(posedge clock); while (busy === 1'b1);
      repeat (2) @(posedge clock);
      check(addrMatch, k ? expMatch(a, 8'h40, 16'h090B) : 8'h00);
      check(matchCnt, 2);
      bus(1'b0, OFS_BCCOUNT, 32'h0, rd);
      check(rd, 32'd56);
      benchEvt.endEvt <= 1'b1;
      @(posedge clock);
      benchEvt.endEvt <= 1'b0;
      benchEvt.receiving <= 1'b0;
      @(posedge clock);
      bus(1'b0, OFS_BCCOUNT, 32'h0, rd);
      check(rd, 32'h0);
    end
    for (int j = 0; j < 4; j++) begin
      bus(1'b1, OFS_CTRL, {24'h0, ctl[j]}, rd);
      bus(1'b1, OFS_IFSGAP, ifs[j], rd);
      benchEvt.endEvt <= 1'b1;
      @(posedge clock);
      benchEvt.endEvt <= 1'b0;
      // The end event stood one cycle before this loop starts sampling
      n = 1;
      forever begin
        @(posedge clock);
        if (txFirstBit === 1'b1 || n == 200) break;
        n++;
      end
      check(n, (ctl[j][0] && ctl[j][2:1] != 2'h0) ? gapCycles(ifs[j]) : 200);
    end
    // Departure-angle transmit with no received length: minimum tone extension
    bus(1'b1, OFS_DFCFG, DFCFG_RST | 32'h0000_0001, rd);
    crcDone <= 1'b1;
    @(posedge clock);
    crcDone <= 1'b0;
    n = 0;
    nSw = 0;
    nIq = 0;
    repeat (200) begin
      @(posedge clock);
      if (cteActive === 1'b1 && cteToneOne === 1'b1) n++;
      if (antSw === 1'b1) nSw++;
      if (iqSample === 1'b1) nIq++;
    end
    check(n, CTE_MIN_US * US_CYCLES);
    check(32'(nSw != 0), 32'h1);
    check(nIq, 0);
    report_and_stop();
  end
endmodule // tb
